// *** src/weld_params.svh ***
`ifndef WELD_PARAMS_SVH
`define WELD_PARAMS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_MHZ     20
`define CLK_KHZ     20000
`define DB_US       1
`define DB_CYC      (`DB_US * `CLK_MHZ)
`define FLASH_MS    250
`define FLASH_CYC   (`FLASH_MS * `CLK_KHZ)
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define A_CTRL      8'h00
`define A_TIMES     8'h04
`define A_PTMO      8'h08
`define A_MSEL      8'h0C
`define A_ENTER     8'h10
`define A_STATUS    8'h14
`define A_MRD       8'h18
// ----------------------------------------
// Fields, resets, codes
// ----------------------------------------
`define C_WMODE     0
`define C_PMODE     1
`define C_CLRALL    8
`define PTMO_RST    16'hFFFF
`define MEM_DEF     8'h00
`define N_SCH       16
`define N_MEM       20
`define CODE_STOP   8'hE5
`define CODE_ER     8'hEA
`define CODE_EF     8'hEF
`define CODE_MEM    8'h32
`define CODE_FLOW   8'h01
`define CODE_PRESS  8'h15
`endif

// *** src/weld_pkg.sv ***
package weld_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_SQZ   = 3'h1,
    S_PHOLD = 3'h3,
    S_WELD  = 3'h2,
    S_HOLD  = 3'h6,
    S_OFF   = 3'h7
  } seq_t;
  typedef logic [7:0] byte_t;
endpackage

// *** src/weld_interlock_supervisor.sv ***
// How it works
// - Hold after squeeze until pressure, flash squeeze
// - Long pressure hold flashes 15, no abort
// - Weld time 00 skips pressure check
// - Stop open kills valves and firing immediately
// - Stop flashes tag on both displays
// - After stop, fresh pilot needed to restart
// - No-weld runs sequence, no firing, LED on
// - Fire only in weld mode, inhibit closed
// - Coolant open refuses new initiation
// - Coolant opening mid-sequence lets sequence finish
// - Coolant fault shows 01 until reclosed
// - Heatsink open refuses new initiation
// - Heatsink opening mid-sequence lets sequence finish
// - Heatsink fault shows 01 until reclosed
// - Scan storage at power-up and stop exit
// - Bad data flashes 32, tag alternates schedule
// - Extended area bad shows extended tag
// - Memory fault blocks any weld sequence
// - Select press stops memory fault flashing
// - Program mode edit, enter, operate clears fault
// - Clear-all restores every location to default
// - Initiation latched, no re-initiation mid-sequence
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`include "weld_params.svh"
`timescale 1ns/1ps
`default_nettype none
module weld_interlock_supervisor #(
  parameter int FLASH_CYC = `FLASH_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             pressure_input,
  input  wire logic             stop_input,
  input  wire logic             weld_inhibit_input,
  input  wire logic             coolant_flow_input,
  input  wire logic             heatsink_temp_input,
  input  wire logic             pilot_second_stage,
  input  wire logic             select_button,
  output logic                  valve_out,
  output logic                  fire_pulse,
  output logic                  squeeze_led,
  output logic                  weld_led,
  output logic                  no_weld_led,
  output weld_pkg::byte_t       data_disp,
  output weld_pkg::byte_t       sched_disp,
  output logic                  data_dark,
  output logic                  sched_dark
);
  import weld_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int NI = 7;
  localparam logic [4:0] DBC = 5'(`DB_CYC);
  localparam logic [4:0] LAST = 5'(`N_MEM - 1);
  localparam logic [4:0] NSCH = 5'(`N_SCH);

  typedef struct packed {
    logic [NI-1:0]          s1;
    logic [NI-1:0]          s2;
    logic [NI-1:0]          db;
    logic [NI-1:0]          dbp;
    logic [NI-1:0][4:0]     dc;
    seq_t                   st;
    logic [15:0]            tmr;
    logic [15:0]            ptm;
    logic                   f15;
    logic                   valve;
    logic                   fire;
    logic                   sqzled;
    logic                   diag;
    logic [4:0]             di;
    logic                   mfault;
    logic                   mext;
    logic [4:0]             mloc;
    logic                   mack;
    logic [`N_MEM-1:0][7:0] mem;
    logic                   wmode;
    logic                   pmode;
    logic [3:0]             sch;
    logic [23:0]            times;
    logic [15:0]            ptmo;
    logic [4:0]             maddr;
    logic [7:0]             edata;
    logic                   wpend;
    logic [7:0]             waddr;
    logic [31:0]            rdata;
    logic [22:0]            fcnt;
    logic                   fph;
    logic [7:0]             dd;
    logic [7:0]             sd;
    logic                   ddark;
    logic                   sdark;
  } st_t;

  st_t q;
  st_t d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic bcd_ok(input logic [7:0] v);
    bcd_ok = (v[7:4] < 4'hA) && (v[3:0] < 4'hA);
  endfunction

  function automatic logic [7:0] bcd_bin(input logic [7:0] v);
    bcd_bin = ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
  endfunction

  logic [NI-1:0] raw;
  logic          press_ok, stop_ok, inh_ok, flow_ok, heat_ok, pil_rise, sel_rise;
  logic          fire_ok, may_init, weld_zero;
  logic [7:0]    wtime;
  logic          addr_ph;

  assign raw = {select_button, pilot_second_stage, heatsink_temp_input,
                coolant_flow_input, weld_inhibit_input, stop_input, pressure_input};
  assign press_ok  = q.db[0];
  assign stop_ok   = q.db[1];
  assign inh_ok    = q.db[2];
  assign flow_ok   = q.db[3];
  assign heat_ok   = q.db[4];
  assign pil_rise  = q.db[5] & ~q.dbp[5];
  assign sel_rise  = q.db[6] & ~q.dbp[6];
  assign wtime     = bcd_bin(q.mem[q.sch]);
  assign weld_zero = (q.mem[q.sch] == 8'h00);
  assign fire_ok   = q.wmode & inh_ok;
  assign may_init  = pil_rise & stop_ok & flow_ok & heat_ok
                   & ~q.mfault & ~q.diag & ~q.pmode;
  assign addr_ph   = hsel & hready & htrans[1];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    // Only the second stage feeds the filter; the first stays private
    d.s1  = raw;
    d.s2  = q.s1;
    d.dbp = q.db;
    for (int i = 0; i < NI; i++) begin
      if (q.s2[i] == q.db[i]) begin
        d.dc[i] = 5'h00;
      end else if (q.dc[i] == DBC - 5'h01) begin
        d.db[i] = q.s2[i];
        d.dc[i] = 5'h00;
      end else begin
        d.dc[i] = q.dc[i] + 5'h01;
      end
    end

    // Flash phase
    if (q.fcnt == 23'(FLASH_CYC - 1)) begin
      d.fcnt = 23'h0;
      d.fph  = ~q.fph;
    end else begin
      d.fcnt = q.fcnt + 23'h1;
    end

    // Bus writes in data phase
    d.wpend = addr_ph & hwrite;
    d.waddr = haddr[7:0];
    if (q.wpend) begin
      unique case (q.waddr)
        `A_CTRL: begin
          d.wmode = hwdata[`C_WMODE];
          d.pmode = hwdata[`C_PMODE];
          d.sch   = hwdata[7:4];
          if (hwdata[`C_CLRALL] && q.pmode) begin
            d.mem = '{default: `MEM_DEF};
          end
          if (q.pmode && !hwdata[`C_PMODE]) begin
            d.diag = 1'b1;
            d.di   = 5'h00;
          end
        end
        `A_TIMES: d.times = hwdata[23:0];
        `A_PTMO:  d.ptmo  = hwdata[15:0];
        `A_MSEL: begin
          d.maddr = (hwdata[4:0] > LAST) ? LAST : hwdata[4:0];
          d.edata = hwdata[15:8];
        end
        `A_ENTER: if (q.pmode) d.mem[q.maddr] = q.edata;
        default: ;
      endcase
    end

    // Register reads, latched in address phase
    d.rdata = 32'h0;
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        `A_CTRL:   d.rdata = {24'h0, q.sch, 2'b00, q.pmode, q.wmode};
        `A_TIMES:  d.rdata = {8'h0, q.times};
        `A_PTMO:   d.rdata = {16'h0, q.ptmo};
        `A_MSEL:   d.rdata = {16'h0, q.edata, 3'b000, q.maddr};
        `A_STATUS: d.rdata = {13'h0, q.mloc, q.mext, q.mfault, q.diag, q.f15,
                              ~heat_ok, ~flow_ok, ~stop_ok, q.mack, q.fire, q.valve, 1'b0, q.st};
        `A_MRD:    d.rdata = {24'h0, q.mem[q.maddr]};
        default:   d.rdata = 32'h0;
      endcase
    end

    // Storage scan, one location a cycle
    if (q.diag) begin
      if (!bcd_ok(q.mem[q.di])) begin
        d.mfault = 1'b1;
        d.mloc   = q.di;
        d.mext   = (q.di >= NSCH);
        d.mack   = 1'b0;
        d.diag   = 1'b0;
      end else if (q.di == LAST) begin
        d.mfault = 1'b0;
        d.diag   = 1'b0;
      end else begin
        d.di = q.di + 5'h01;
      end
    end
    if (sel_rise && q.mfault) begin
      d.mack = 1'b1;
    end

    // Sequencer
    d.tmr = q.tmr + 16'h1;
    unique case (q.st)
      S_IDLE: begin
        d.tmr = 16'h0;
        d.f15 = 1'b0;
        if (may_init) begin
          d.st = S_SQZ;
        end
      end
      S_SQZ: if (q.tmr >= {8'h0, q.times[7:0]}) begin
        d.tmr = 16'h0;
        d.ptm = 16'h0;
        if (weld_zero) begin
          d.st = S_HOLD;
        end else if (press_ok) begin
          d.st = S_WELD;
        end else begin
          d.st = S_PHOLD;
        end
      end
      S_PHOLD: begin
        d.tmr = 16'h0;
        if (press_ok) begin
          d.st = S_WELD;
        end else if (q.ptm == q.ptmo) begin
          d.f15 = 1'b1;
        end else begin
          d.ptm = q.ptm + 16'h1;
        end
      end
      S_WELD: if (q.tmr + 16'h1 >= {8'h0, wtime}) begin
        d.tmr = 16'h0;
        d.st  = S_HOLD;
      end
      S_HOLD: if (q.tmr >= {8'h0, q.times[15:8]}) begin
        d.tmr = 16'h0;
        d.st  = S_OFF;
      end
      S_OFF: if (q.tmr >= {8'h0, q.times[23:16]}) begin
        d.st = S_IDLE;
      end
    endcase

    // Stop aborts everything and rescans storage on release
    if (!stop_ok) begin
      d.st  = S_IDLE;
      d.tmr = 16'h0;
      d.f15 = 1'b0;
    end
    if (stop_ok && !q.dbp[1] && q.db[1]) begin
      d.diag = 1'b1;
      d.di   = 5'h00;
    end

    // Outputs, registered
    d.valve  = stop_ok && (d.st != S_IDLE) && (d.st != S_OFF);
    d.fire   = stop_ok && (d.st == S_WELD) && fire_ok;
    d.sqzled = (d.st == S_SQZ) || ((d.st == S_PHOLD) && q.fph);

    // Display: stop first, then storage, then contact faults
    d.ddark = 1'b0;
    d.sdark = 1'b0;
    d.dd    = wtime;
    d.sd    = {4'h0, q.sch};
    if (!stop_ok) begin
      d.dd    = `CODE_STOP;
      d.sd    = `CODE_STOP;
      d.ddark = q.fph;
      d.sdark = q.fph;
    end else if (q.mfault) begin
      d.dd    = `CODE_MEM;
      d.ddark = q.fph & ~q.mack;
      if (q.fph) begin
        d.sd = `CODE_ER;
      end else begin
        d.sd = q.mext ? `CODE_EF : {3'h0, q.mloc};
      end
    end else if (!flow_ok || !heat_ok) begin
      d.dd = `CODE_FLOW;
    end else if (q.f15) begin
      d.dd    = `CODE_PRESS;
      d.ddark = q.fph;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q       <= '0;
      q.diag  <= 1'b1;
      q.ptmo  <= `PTMO_RST;
    end else begin
      q <= d;
    end
  end

  assign hrdata      = q.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign valve_out   = q.valve;
  assign fire_pulse  = q.fire;
  assign squeeze_led = q.sqzled;
  assign weld_led    = q.wmode;
  assign no_weld_led = ~fire_ok;
  assign data_disp   = q.dd;
  assign sched_disp  = q.sd;
  assign data_dark   = q.ddark;
  assign sched_dark  = q.sdark;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  stop_kills_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !stop_ok |=> !q.valve && !q.fire) else $error("output live during stop");
  fire_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.fire |-> $past(q.wmode && q.db[2])) else $error("fire without weld enable");
  no_reinit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_IDLE && $past(q.st) == S_IDLE && q.st != d.st |-> pil_rise)
    else $error("start without pilot edge");
  interlock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_IDLE && (!flow_ok || !heat_ok || q.mfault) |=> q.st == S_IDLE)
    else $error("start while interlocked");
  hold_press_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_PHOLD && !press_ok && stop_ok |=> q.st == S_PHOLD) else $error("left hold early");
  skip_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_SQZ && d.st != S_SQZ && stop_ok && weld_zero |=> q.st == S_HOLD)
    else $error("weld 00 not skipped");
  press_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
    q.st == S_PHOLD && !press_ok && stop_ok && q.ptm == q.ptmo |=> q.f15)
    else $error("pressure timeout missed");
  mem_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_ok && q.mfault |=> q.dd == `CODE_MEM) else $error("memory code missing");
  flow_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_ok && !q.mfault && !flow_ok |=> q.dd == `CODE_FLOW) else $error("flow code missing");
  rescan_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_ok && !q.dbp[1] && q.db[1] |=> q.diag && q.di == 5'h00) else $error("no rescan");
endmodule
`default_nettype wire

// *** bench/contact_panel.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Switch contacts and front panel
// ----------------------------------------
// Contacts change only on a clock edge, one cycle after the request
module contact_panel (
  input  wire logic       hclk,
  input  wire logic [6:0] want,
  output logic            pressure_input,
  output logic            stop_input,
  output logic            weld_inhibit_input,
  output logic            coolant_flow_input,
  output logic            heatsink_temp_input,
  output logic            pilot_second_stage,
  output logic            select_button
);
  logic [6:0] q = 7'h1D;
  always @(posedge hclk) begin
    q <= want;
  end
  assign {select_button, pilot_second_stage, heatsink_temp_input, coolant_flow_input,
          weld_inhibit_input, stop_input, pressure_input} = q;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`include "weld_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import weld_pkg::*;
  localparam int P = 0, S = 1, I = 2, F = 3, H = 4, L = 5, B = 6;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, valve_out, fire_pulse, squeeze_led, weld_led, no_weld_led;
  logic        data_dark, sched_dark, pr, st, wi, cf, ht, pl, sb;
  byte_t       data_disp, sched_disp;
  logic [6:0]  want = 7'h1D;
  int          num_errors = 0, total_checks = 0, fire_n = 0, valve_n = 0, f0, v0, c, a, n0, n1, n2;
  // ----------------------------------------
  // Clock, contacts, design
  // ----------------------------------------
  initial forever #25 hclk = ~hclk;
  always @(posedge hclk) begin
    fire_n  <= fire_n + int'(fire_pulse);
    valve_n <= valve_n + int'(valve_out);
  end
  contact_panel panel_u (.hclk(hclk), .want(want), .pressure_input(pr), .stop_input(st),
    .weld_inhibit_input(wi), .coolant_flow_input(cf), .heatsink_temp_input(ht),
    .pilot_second_stage(pl), .select_button(sb));
  weld_interlock_supervisor #(.FLASH_CYC(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pressure_input(pr), .stop_input(st), .weld_inhibit_input(wi), .coolant_flow_input(cf),
    .heatsink_temp_input(ht), .pilot_second_stage(pl), .select_button(sb),
    .valve_out(valve_out), .fire_pulse(fire_pulse), .squeeze_led(squeeze_led),
    .weld_led(weld_led), .no_weld_led(no_weld_led), .data_disp(data_disp),
    .sched_disp(sched_disp), .data_dark(data_dark), .sched_dark(sched_dark));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1;
    haddr  <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task setc(input int i, input logic v);
    @(posedge hclk);
    want[i] <= v;
    repeat (30) @(posedge hclk);
  endtask
  task pilot;
    f0 = fire_n;
    v0 = valve_n;
    setc(L, 1);
    setc(L, 0);
  endtask
  task store(input int ad, input logic [7:0] d);
    bus(1, `A_CTRL, 32'h2);
    bus(1, `A_MSEL, {16'h0, d, 3'h0, 5'(ad)});
    bus(1, `A_ENTER, 32'h0);
    bus(1, `A_CTRL, 32'h1);
    repeat (40) @(posedge hclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    repeat (10) @(posedge hclk);
    chk(data_disp, `CODE_STOP);
    chk(sched_disp, `CODE_STOP);
    chk(valve_out, 0);
    chk({hreadyout, hresp}, 2'b10);
    setc(S, 1);
    repeat (30) @(posedge hclk);
    bus(0, `A_STATUS, 0);
    chk(rd[11], 0);
    bus(0, `A_PTMO, 0);
    chk(rd, 32'h0000FFFF);
    bus(0, `A_CTRL, 0);
    chk(rd, 0);
    bus(0, 8'h40, 0);
    chk(rd, 0);
  endtask
  task t_skip;
    bus(1, `A_TIMES, 32'h00020202);
    bus(1, `A_PTMO, 32'hA);
    setc(P, 0);
    pilot;
    repeat (20) @(posedge hclk);
    chk(valve_n - v0, 6);
    chk(fire_n - f0, 0);
  endtask
  task t_hold;
    store(0, 8'h05);
    bus(0, `A_MRD, 0);
    chk(rd, 32'h5);
    pilot;
    bus(0, `A_STATUS, 0);
    chk(rd[2:0], S_PHOLD);
    chk(data_disp, `CODE_PRESS);
    chk(valve_out, 1);
    n0 = 0;
    n1 = 0;
    repeat (16) begin
      @(posedge hclk);
      n0 += int'(squeeze_led);
      n1 += int'(data_dark);
    end
    chk(n0, 8);
    chk(n1, 8);
    @(posedge hclk);
    want[F] <= 0;
    want[H] <= 0;
    setc(P, 1);
    repeat (20) @(posedge hclk);
    chk(fire_n - f0, 5);
    setc(F, 1);
    setc(H, 1);
  endtask
  task t_noweld;
    setc(I, 0);
    chk(no_weld_led, 1);
    chk(weld_led, 1);
    pilot;
    repeat (20) @(posedge hclk);
    chk(fire_n - f0, 0);
    chk(valve_n - v0, 11);
    setc(I, 1);
    chk(no_weld_led, 0);
  endtask
  task t_block;
    for (int i = 0; i < 2; i++) begin
      c = i ? H : F;
      setc(c, 0);
      chk(data_disp, `CODE_FLOW);
      pilot;
      chk(valve_n - v0, 0);
      setc(c, 1);
      chk(data_disp === `CODE_FLOW, 0);
    end
  endtask
  task t_stop;
    v0 = valve_n;
    @(posedge hclk);
    want[L] <= 1;
    repeat (3) @(posedge hclk);
    want[L] <= 0;
    repeat (40) @(posedge hclk);
    chk(valve_n - v0, 0);
    setc(P, 0);
    pilot;
    chk(valve_out, 1);
    @(posedge hclk);
    want[S] <= 0;
    want[P] <= 1;
    repeat (25) @(posedge hclk);
    chk({valve_out, fire_pulse}, 0);
    chk({data_disp, sched_disp}, {`CODE_STOP, `CODE_STOP});
    n0 = 0;
    n1 = 0;
    repeat (16) begin
      @(posedge hclk);
      n0 += int'(data_dark);
      n1 += int'(sched_dark);
    end
    chk(n0, 8);
    chk(n1, 8);
    v0 = valve_n;
    setc(S, 1);
    repeat (40) @(posedge hclk);
    chk(valve_n - v0, 0);
  endtask
  task t_mem;
    for (int i = 0; i < 2; i++) begin
      a = i ? 17 : 3;
      store(a, 8'h0A);
      bus(0, `A_STATUS, 0);
      chk({rd[18:12]}, {5'(a), 1'(i), 1'b1});
      chk(data_disp, `CODE_MEM);
      n0 = 0;
      n1 = 0;
      n2 = 0;
      repeat (16) begin
        @(posedge hclk);
        n0 += int'(sched_disp == `CODE_ER);
        n1 += int'(sched_disp == (i ? `CODE_EF : 8'(a)));
        n2 += int'(data_dark);
      end
      chk(n0, 8);
      chk(n1, 8);
      chk(n2, 8);
      pilot;
      chk(valve_n - v0, 0);
      setc(B, 1);
      setc(B, 0);
      bus(0, `A_STATUS, 0);
      chk(rd[6], 1);
      n2 = 0;
      repeat (16) begin
        @(posedge hclk);
        n2 += int'(data_dark);
      end
      chk(n2, 0);
      store(a, 8'h00);
      bus(0, `A_STATUS, 0);
      chk(rd[12], 0);
    end
  endtask
  task t_clear;
    store(0, 8'h05);
    bus(1, `A_CTRL, 32'h2);
    bus(1, `A_CTRL, 32'h102);
    bus(0, `A_MRD, 0);
    chk(rd, 0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    t_reset;
    t_skip;
    t_hold;
    t_noweld;
    t_block;
    t_stop;
    t_mem;
    t_clear;
    stop_test;
  end
  // Whole run needs about 1700 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
